// ==== core/oag_params.svh ====
// Constants of the operand address generator: opcode rows, lengths, address limits
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH

// ***********************************************
// Opcode rows (upper nibble of the opcode)
// ***********************************************
`define OAG_ROW_BRBIT   4'h0
`define OAG_ROW_BITSC   4'h1
`define OAG_ROW_RMW_DIR 4'h3
`define OAG_ROW_RMW_IX1 4'h6
`define OAG_ROW_RMW_IX  4'h7
`define OAG_ROW_RM_DIR  4'hB
`define OAG_ROW_RM_EXT  4'hC
`define OAG_ROW_RM_IX2  4'hD
`define OAG_ROW_RM_IX1  4'hE
`define OAG_ROW_RM_IX   4'hF

// ***********************************************
// Opcode field positions: row nibble and operation nibble
// ***********************************************
`define OAG_ROW_MSB     7
`define OAG_ROW_LSB     4
`define OAG_LOW_MSB     3
`define OAG_LOW_LSB     0

// ***********************************************
// Register/memory operations with no register operand
// ***********************************************
`define OAG_OP_JUMP     4'hC
`define OAG_OP_JUMP_SUB 4'hD

// ***********************************************
// Instruction lengths and address figures
// ***********************************************
`define OAG_LEN_1       2'h1
`define OAG_LEN_2       2'h2
`define OAG_LEN_3       2'h3
`define OAG_PAGE0_HI    8'h00
`define OAG_IX1_MAX     16'h01FE
`define OAG_RESET_PC    16'h0000
`define OAG_PC_STEP     16'h0001
`define OAG_ZERO_BYTE   8'h00
`define OAG_ZERO_ADDR   16'h0000

`endif

// ==== core/oag_pkg.sv ====
// Types shared by the operand address generator modules
`default_nettype none

package oag_pkg;

	// Addressing mode of the fetched instruction
	typedef enum logic [2:0] {
		OAG_M_NONE = 3'h0,
		OAG_M_DIR  = 3'h1,
		OAG_M_EXT  = 3'h2,
		OAG_M_IX   = 3'h3,
		OAG_M_IX1  = 3'h4,
		OAG_M_IX2  = 3'h5
	} oag_mode_t;

	// Instruction class as far as address forming cares
	typedef enum logic [2:0] {
		OAG_C_NONE   = 3'h0,
		OAG_C_REGMEM = 3'h1,
		OAG_C_JUMP   = 3'h2,
		OAG_C_RMW    = 3'h3,
		OAG_C_BITSC  = 3'h4,
		OAG_C_BRBIT  = 3'h5
	} oag_class_t;

	// Fetch sequencer states, one-hot
	typedef enum logic [7:0] {
		OAG_S_RD_OP  = 8'h01,
		OAG_S_CAP_OP = 8'h02,
		OAG_S_RD_B1  = 8'h04,
		OAG_S_CAP_B1 = 8'h08,
		OAG_S_RD_B2  = 8'h10,
		OAG_S_CAP_B2 = 8'h20,
		OAG_S_CALC   = 8'h40,
		OAG_S_DONE   = 8'h80
	} oag_state_t;

	// Whole state of the top module
	typedef struct packed {
		oag_state_t st;
		logic [15:0] pc;
		logic [15:0] start_pc;
		logic [7:0]  opcode;
		logic [7:0]  b1;
		logic [7:0]  b2;
		logic [7:0]  idx;
		logic [15:0] ea;
		oag_mode_t   mode;
		oag_class_t  cls;
		logic [1:0]  len;
		logic        sup;
	} oag_regs_t;

endpackage

`default_nettype wire

// ==== core/oag_decode.sv ====
// Opcode classifier: addressing mode, class, length and support flag
`include "oag_params.svh"
`default_nettype none

module oag_decode (
	input  wire logic [7:0]            opcode,
	output var  oag_pkg::oag_mode_t    mode,
	output var  oag_pkg::oag_class_t   cls,
	output logic [1:0]                 len,
	output logic                       supported
);
	import oag_pkg::*;

	logic [3:0] op_row;
	logic [3:0] op_low;

	// Opcode fields: the upper nibble picks the row, the lower nibble the operation
	assign op_row = opcode[`OAG_ROW_MSB:`OAG_ROW_LSB];
	assign op_low = opcode[`OAG_LOW_MSB:`OAG_LOW_LSB];

	// Jumps share the register/memory rows but carry no register operand
	function automatic oag_class_t rm_class(input logic [3:0] low);
		rm_class = (low == `OAG_OP_JUMP || low == `OAG_OP_JUMP_SUB) ? OAG_C_JUMP : OAG_C_REGMEM;
	endfunction

	// Length follows from the mode alone, except for the branch-on-bit form
	function automatic logic [1:0] mode_len(input oag_mode_t m);
		case (m)
			OAG_M_DIR, OAG_M_IX1: mode_len = `OAG_LEN_2;
			OAG_M_EXT, OAG_M_IX2: mode_len = `OAG_LEN_3;
			default:              mode_len = `OAG_LEN_1;
		endcase
	endfunction

	// Row decode; rows not listed belong to modes handled elsewhere
	always_comb begin
		supported = 1'b1;
		case (op_row)
			`OAG_ROW_BRBIT: begin
				mode = OAG_M_DIR;
				cls  = OAG_C_BRBIT;
			end
			`OAG_ROW_BITSC: begin
				mode = OAG_M_DIR;
				cls  = OAG_C_BITSC;
			end
			`OAG_ROW_RMW_DIR: begin
				mode = OAG_M_DIR;
				cls  = OAG_C_RMW;
			end
			`OAG_ROW_RMW_IX1: begin
				mode = OAG_M_IX1;
				cls  = OAG_C_RMW;
			end
			`OAG_ROW_RMW_IX: begin
				mode = OAG_M_IX;
				cls  = OAG_C_RMW;
			end
			`OAG_ROW_RM_DIR: begin
				mode = OAG_M_DIR;
				cls  = rm_class(op_low);
			end
			`OAG_ROW_RM_EXT: begin
				mode = OAG_M_EXT;
				cls  = rm_class(op_low);
			end
			`OAG_ROW_RM_IX2: begin
				mode = OAG_M_IX2;
				cls  = rm_class(op_low);
			end
			`OAG_ROW_RM_IX1: begin
				mode = OAG_M_IX1;
				cls  = rm_class(op_low);
			end
			`OAG_ROW_RM_IX: begin
				mode = OAG_M_IX;
				cls  = rm_class(op_low);
			end
			default: begin
				mode      = OAG_M_NONE;
				cls       = OAG_C_NONE;
				supported = 1'b0;
			end
		endcase
		// Branch-on-bit carries a relative byte after its direct byte
		len = (cls == OAG_C_BRBIT) ? `OAG_LEN_3 : mode_len(mode);
	end

endmodule

`default_nettype wire

// ==== core/oag_ea_calc.sv ====
// Effective-address adder for the memory addressing modes
`include "oag_params.svh"
`default_nettype none

module oag_ea_calc (
	input  var  oag_pkg::oag_mode_t mode,
	input  wire logic [7:0]         b1,
	input  wire logic [7:0]         b2,
	input  wire logic [7:0]         idx,
	output logic [15:0]             ea
);
	import oag_pkg::*;

	logic [8:0] short_sum;

	// Nine-bit sum keeps the carry instead of wrapping inside page zero
	assign short_sum = {1'b0, b1} + {1'b0, idx};

	// Address per mode; extended and 16-bit offset take the first byte as high
	always_comb begin
		case (mode)
			OAG_M_DIR: ea = {`OAG_PAGE0_HI, b1};
			OAG_M_EXT: ea = {b1, b2};
			OAG_M_IX:  ea = {`OAG_PAGE0_HI, idx};
			OAG_M_IX1: ea = {7'h00, short_sum};
			OAG_M_IX2: ea = {b1, b2} + {`OAG_ZERO_BYTE, idx};
			default:   ea = `OAG_ZERO_ADDR;
		endcase
	end

endmodule

`default_nettype wire

// ==== core/oag_top.sv ====
// Operand fetch sequencer and effective-address generator of the CPU
//
// Notes on behaviour
// - Direct form is two bytes; address high byte is zero, page zero only.
// - Branch-on-bit set/clear is three bytes: direct operand byte, then relative byte.
// - Direct accepted by load, store, arithmetic, logic, rmw, test, bit ops, jumps.
// - Extended form is three bytes: high address byte first, then low byte.
// - Extended only for register/memory ops and jumps; no rmw or bit forms.
// - Indexed without offset is one byte; address is zero high byte, index low.
// - Indexed 8-bit offset is two bytes; address is index plus offset, unsigned.
// - The 8-bit offset sum keeps its carry; highest address is 510.
// - Indexed 16-bit offset is three bytes; index plus 16-bit offset, unsigned.
// - The 16-bit offset takes high byte first, low byte second.
// - Read-modify-write and test have no-offset and 8-bit indexed forms only.
// - Register/memory ops and jumps have all three indexed forms.
`include "oag_params.svh"
`default_nettype none

module oag_top (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [7:0]            mem_rdata,
	input  wire logic [7:0]            index_reg,
	input  wire logic                  ea_accept,
	input  wire logic                  pc_load,
	input  wire logic [15:0]           pc_target,
	output logic                       mem_rd,
	output logic [15:0]                mem_addr,
	output logic                       ea_valid,
	output logic [15:0]                ea,
	output var  oag_pkg::oag_mode_t    mode,
	output var  oag_pkg::oag_class_t   op_class,
	output logic [7:0]                 opcode,
	output logic [7:0]                 operand_hi,
	output logic [7:0]                 operand_lo,
	output logic [1:0]                 instr_len,
	output logic                       mode_supported,
	output logic [15:0]                next_pc,
	output logic [15:0]                start_pc
);
	import oag_pkg::*;

	// ***********************************************
	// State and helpers
	// ***********************************************
	oag_regs_t  s;
	oag_regs_t  next_s;
	oag_mode_t  dec_mode;
	oag_class_t dec_cls;
	logic [1:0] dec_len;
	logic       dec_sup;
	logic [15:0] calc_ea;

	// Decode straight off the read data so the opcode cycle latches its results
	oag_decode u_decode (
		.opcode    (mem_rdata),
		.mode      (dec_mode),
		.cls       (dec_cls),
		.len       (dec_len),
		.supported (dec_sup)
	);

	// Index is sampled in the calculation cycle, after the last byte is in
	oag_ea_calc u_ea (
		.mode (s.mode),
		.b1   (s.b1),
		.b2   (s.b2),
		.idx  (index_reg),
		.ea   (calc_ea)
	);

	// ***********************************************
	// Sequencer
	// ***********************************************
	// Memory answers the cycle after a read strobe; each byte costs two cycles
	always_comb begin
		next_s = s;
		case (s.st)
			OAG_S_RD_OP: begin
				next_s.start_pc = s.pc;
				next_s.st       = OAG_S_CAP_OP;
			end
			OAG_S_CAP_OP: begin
				next_s.opcode = mem_rdata;
				next_s.mode   = dec_mode;
				next_s.cls    = dec_cls;
				next_s.len    = dec_len;
				next_s.sup    = dec_sup;
				next_s.b1     = `OAG_ZERO_BYTE;
				next_s.b2     = `OAG_ZERO_BYTE;
				next_s.pc     = s.pc + `OAG_PC_STEP;
				next_s.st     = (dec_len == `OAG_LEN_1) ? OAG_S_CALC : OAG_S_RD_B1;
			end
			OAG_S_RD_B1: begin
				next_s.st = OAG_S_CAP_B1;
			end
			OAG_S_CAP_B1: begin
				next_s.b1 = mem_rdata;
				next_s.pc = s.pc + `OAG_PC_STEP;
				next_s.st = (s.len == `OAG_LEN_3) ? OAG_S_RD_B2 : OAG_S_CALC;
			end
			OAG_S_RD_B2: begin
				next_s.st = OAG_S_CAP_B2;
			end
			OAG_S_CAP_B2: begin
				next_s.b2 = mem_rdata;
				next_s.pc = s.pc + `OAG_PC_STEP;
				next_s.st = OAG_S_CALC;
			end
			OAG_S_CALC: begin
				next_s.ea  = calc_ea;
				next_s.idx = index_reg;
				next_s.st  = OAG_S_DONE;
			end
			OAG_S_DONE: begin
				// Hold the result until the executor takes it; a jump reloads the counter
				if (ea_accept) begin
					next_s.pc = pc_load ? pc_target : s.pc;
					next_s.st = OAG_S_RD_OP;
				end
			end
			default: begin
				next_s.st = OAG_S_RD_OP;
			end
		endcase
	end

	// Register the whole state; fetching starts at the reset address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s.st       <= OAG_S_RD_OP;
			s.pc       <= `OAG_RESET_PC;
			s.start_pc <= `OAG_RESET_PC;
			s.opcode   <= `OAG_ZERO_BYTE;
			s.b1       <= `OAG_ZERO_BYTE;
			s.b2       <= `OAG_ZERO_BYTE;
			s.idx      <= `OAG_ZERO_BYTE;
			s.ea       <= `OAG_ZERO_ADDR;
			s.mode     <= OAG_M_NONE;
			s.cls      <= OAG_C_NONE;
			s.len      <= `OAG_LEN_1;
			s.sup      <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// ***********************************************
	// Outputs
	// ***********************************************
	// Strobes are decoded from state; data all come from flip-flops
	assign mem_rd         = (s.st == OAG_S_RD_OP) || (s.st == OAG_S_RD_B1) || (s.st == OAG_S_RD_B2);
	assign mem_addr       = s.pc;
	assign ea_valid       = (s.st == OAG_S_DONE);
	assign ea             = s.ea;
	assign mode           = s.mode;
	assign op_class       = s.cls;
	assign opcode         = s.opcode;
	assign operand_hi     = s.b1;
	assign operand_lo     = s.b2;
	assign instr_len      = s.len;
	assign mode_supported = s.sup;
	assign next_pc        = s.pc;
	assign start_pc       = s.start_pc;

	// ***********************************************
	// Checks
	// ***********************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_dir_page_zero: assert property (
		ea_valid && mode == OAG_M_DIR |-> ea[15:8] == `OAG_PAGE0_HI && ea[7:0] == operand_hi)
		else $error("direct address left page zero");

	a_brbit_form: assert property (
		ea_valid && op_class == OAG_C_BRBIT |-> mode == OAG_M_DIR && instr_len == `OAG_LEN_3)
		else $error("branch-on-bit not three-byte direct");

	a_dir_accepted: assert property (
		ea_valid && mode == OAG_M_DIR |-> mode_supported && op_class != OAG_C_NONE)
		else $error("direct form not accepted");

	a_ext_bytes: assert property (
		ea_valid && mode == OAG_M_EXT |-> ea == {operand_hi, operand_lo} && instr_len == `OAG_LEN_3)
		else $error("extended address misassembled");

	a_ext_classes: assert property (
		ea_valid && mode == OAG_M_EXT |-> op_class inside {OAG_C_REGMEM, OAG_C_JUMP})
		else $error("extended form on wrong class");

	a_ix_address: assert property (
		ea_valid && mode == OAG_M_IX |-> ea == {`OAG_PAGE0_HI, s.idx} && instr_len == `OAG_LEN_1)
		else $error("indexed no-offset address wrong");

	a_ix1_sum: assert property (
		ea_valid && mode == OAG_M_IX1 |->
		ea == ({`OAG_ZERO_BYTE, operand_hi} + {`OAG_ZERO_BYTE, s.idx}) && instr_len == `OAG_LEN_2)
		else $error("indexed 8-bit offset sum wrong");

	a_ix1_limit: assert property (
		ea_valid && mode == OAG_M_IX1 |-> ea <= `OAG_IX1_MAX)
		else $error("indexed 8-bit offset beyond 510");

	a_ix2_sum: assert property (
		ea_valid && mode == OAG_M_IX2 |->
		ea == ({operand_hi, operand_lo} + {`OAG_ZERO_BYTE, s.idx}) && instr_len == `OAG_LEN_3)
		else $error("indexed 16-bit offset sum wrong");

	a_ix2_order: assert property (
		ea_valid && mode == OAG_M_IX2 && s.idx == `OAG_ZERO_BYTE |-> ea == {operand_hi, operand_lo})
		else $error("16-bit offset bytes swapped");

	a_rmw_modes: assert property (
		ea_valid && op_class == OAG_C_RMW |-> mode inside {OAG_M_DIR, OAG_M_IX, OAG_M_IX1})
		else $error("read-modify-write in illegal mode");

	a_regmem_modes: assert property (
		ea_valid && op_class inside {OAG_C_REGMEM, OAG_C_JUMP} |-> mode != OAG_M_NONE)
		else $error("register/memory without address mode");

	a_pc_advance: assert property (
		ea_valid |-> next_pc == start_pc + {14'h0000, instr_len})
		else $error("counter not past instruction");

	a_fetch_next: assert property (
		mem_rd && s.st == OAG_S_RD_B1 |-> mem_addr == start_pc + `OAG_PC_STEP)
		else $error("operand byte not consecutive");

	a_fetch_bound: assert property (
		s.st == OAG_S_RD_OP |-> ##[3:7] ea_valid)
		else $error("address not ready in time");

	// ***********************************************
	// Sequencing checks
	// ***********************************************
	// A parked result must not drift while the executor stalls, or it would act on a mix of two instructions
	a_result_hold: assert property (
		ea_valid && !ea_accept |=> ea_valid && $stable(ea) && $stable(mode) && $stable(next_pc))
		else $error("result changed before accept");

	a_valid_drop: assert property (
		ea_valid && ea_accept |=> !ea_valid && mem_rd)
		else $error("result held after accept");

	a_seq_fetch: assert property (
		ea_valid && ea_accept && !pc_load |=> mem_addr == $past(next_pc))
		else $error("next opcode not after instruction");

	a_jump_fetch: assert property (
		ea_valid && ea_accept && pc_load |=> mem_addr == $past(pc_target))
		else $error("jump target not fetched");

	// Operand reads come two cycles apart, so each one is the previous address plus one
	a_addr_step: assert property (
		mem_rd && s.st != OAG_S_RD_OP |-> mem_addr == $past(mem_addr, 2) + `OAG_PC_STEP)
		else $error("operand read not consecutive");

	a_start_latch: assert property (
		s.st == OAG_S_RD_OP |=> start_pc == $past(mem_addr))
		else $error("opcode address not recorded");

	a_len_range: assert property (
		ea_valid |-> instr_len inside {`OAG_LEN_1, `OAG_LEN_2, `OAG_LEN_3})
		else $error("instruction length out of range");

	// ***********************************************
	// Form and class checks
	// ***********************************************
	a_dir_len: assert property (
		ea_valid && mode == OAG_M_DIR && op_class != OAG_C_BRBIT |-> instr_len == `OAG_LEN_2)
		else $error("direct form not two bytes");

	a_bitop_direct: assert property (
		ea_valid && op_class == OAG_C_BITSC |-> mode == OAG_M_DIR && instr_len == `OAG_LEN_2)
		else $error("bit set/clear not direct");

	a_rmw_no_ext: assert property (
		ea_valid && op_class inside {OAG_C_RMW, OAG_C_BITSC, OAG_C_BRBIT} |-> mode != OAG_M_EXT)
		else $error("extended form on bit or rmw op");

	a_rmw_no_ix2: assert property (
		ea_valid && op_class == OAG_C_RMW |-> mode != OAG_M_IX2 && instr_len != `OAG_LEN_3)
		else $error("read-modify-write with 16-bit offset");

	a_jump_modes: assert property (
		ea_valid && op_class == OAG_C_JUMP |-> mode inside {OAG_M_DIR, OAG_M_EXT, OAG_M_IX, OAG_M_IX1, OAG_M_IX2})
		else $error("jump without address form");

	// Rows outside this block give no address; the executor must steer the counter itself
	a_unsup_zero: assert property (
		ea_valid && !mode_supported |-> ea == `OAG_ZERO_ADDR && mode == OAG_M_NONE && instr_len == `OAG_LEN_1)
		else $error("unsupported row produced an address");

	c_ix2_done: cover property (ea_valid && mode == OAG_M_IX2);
	c_ix1_carry: cover property (ea_valid && mode == OAG_M_IX1 && ea[8]);
	c_brbit_done: cover property (ea_valid && op_class == OAG_C_BRBIT);
	c_ext_jump: cover property (ea_valid && mode == OAG_M_EXT && op_class == OAG_C_JUMP && pc_load && ea_accept);
	c_unsup_done: cover property (ea_valid && !mode_supported);

endmodule

`default_nettype wire

// ==== testbench/oag_mem_model.sv ====
// Program memory model answering the fetch port one cycle after each read strobe
`default_nettype none

module oag_mem_model (
	input  wire logic        clk,
	input  wire logic        mem_rd,
	input  wire logic [15:0] mem_addr,
	output logic [7:0]       mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// ***********************************************
	// Storage and read port
	// ***********************************************
	logic [7:0] mem [0:65535];

	initial mem_rdata = 8'hA5;

	// Data only in the cycle after the strobe; otherwise a toggling pattern so stale bytes never match
	always @(posedge clk) begin
		if (mem_rd)
			mem_rdata <= mem[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the operand address generator
`default_nettype none

module testbench import oag_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// ***********************************************
	// Signals and instances
	// ***********************************************
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  mem_rdata;
	logic [7:0]  index_reg = 8'h00;
	logic        ea_accept = 1'b0;
	logic        pc_load = 1'b0;
	logic [15:0] pc_target = 16'h0000;
	logic        mem_rd;
	logic        ea_valid;
	logic        mode_supported;
	logic [15:0] mem_addr;
	logic [15:0] ea;
	logic [15:0] next_pc;
	logic [15:0] start_pc;
	oag_mode_t   mode;
	oag_class_t  op_class;
	logic [7:0]  opcode;
	logic [7:0]  operand_hi;
	logic [7:0]  operand_lo;
	logic [1:0]  instr_len;
	logic [15:0] cur = 16'h0000;
	int          miscompares = 0;
	int          compares = 0;
	int          cycles = 0;

	oag_top i_dut (.clk, .rst, .mem_rdata, .index_reg, .ea_accept, .pc_load, .pc_target, .mem_rd,
		.mem_addr, .ea_valid, .ea, .mode, .op_class, .opcode, .operand_hi, .operand_lo, .instr_len,
		.mode_supported, .next_pc, .start_pc);

	oag_mem_model i_mem (.clk, .mem_rd, .mem_addr, .mem_rdata);

	always #5 clk = ~clk;

	// Hang guard: a full run needs under two hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			end_sim();
		end
	end

	// ***********************************************
	// Shared tasks
	// ***********************************************
	task automatic end_sim();
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One instruction: place bytes, follow every fetch, judge the result, then accept it
	task automatic run_instr(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
		input logic [7:0] ix, input logic [15:0] x_ea, input logic [2:0] x_m, input logic [2:0] x_c,
		input logic [1:0] x_len, input logic ld, input logic [15:0] tgt);
		int          k;
		int          n;
		logic [15:0] p;
		p = cur;
		k = 0;
		i_mem.mem[p] = b0;
		i_mem.mem[p + 16'h0001] = b1;
		i_mem.mem[p + 16'h0002] = b2;
		index_reg <= ix;
		#1;
		for (n = 0; n < 20 && ea_valid !== 1'b1; n++) begin
			if (mem_rd === 1'b1) begin
				chk("mem_addr", mem_addr, p + 16'(k));
				k++;
			end
			@(posedge clk);
			#1;
		end
		chk("ea_valid", 16'(ea_valid), 16'h0001);
		chk("reads", 16'(k), 16'(x_len));
		chk("ea", ea, x_ea);
		chk("mode", 16'(mode), 16'(x_m));
		chk("op_class", 16'(op_class), 16'(x_c));
		chk("instr_len", 16'(instr_len), 16'(x_len));
		chk("supported", 16'(mode_supported), 16'(x_m != 3'h0));
		chk("opcode", 16'(opcode), 16'(b0));
		chk("operand_hi", 16'(operand_hi), (x_len >= 2'h2) ? 16'(b1) : 16'h0000);
		chk("operand_lo", 16'(operand_lo), (x_len == 2'h3) ? 16'(b2) : 16'h0000);
		chk("start_pc", start_pc, p);
		chk("next_pc", next_pc, p + 16'(x_len));
		@(posedge clk);
		ea_accept <= 1'b1;
		pc_load <= ld;
		pc_target <= tgt;
		@(posedge clk);
		ea_accept <= 1'b0;
		pc_load <= 1'b0;
		cur = ld ? tgt : p + 16'(x_len);
	endtask

	// ***********************************************
	// Scenarios
	// ***********************************************
	task automatic t_reset();
		chk("rst_addr", mem_addr, 16'h0000);
		chk("rst_valid", 16'(ea_valid), 16'h0000);
		chk("rst_mode", 16'(mode), 16'(OAG_M_NONE));
	endtask

	task automatic t_direct();
		run_instr(8'hB6, 8'h45, 8'h00, 8'h99, 16'h0045, OAG_M_DIR, OAG_C_REGMEM, 2'h2, 1'b0, 16'h0000);
		run_instr(8'h3C, 8'hFF, 8'h00, 8'h10, 16'h00FF, OAG_M_DIR, OAG_C_RMW, 2'h2, 1'b0, 16'h0000);
		run_instr(8'h14, 8'h22, 8'h00, 8'h00, 16'h0022, OAG_M_DIR, OAG_C_BITSC, 2'h2, 1'b0, 16'h0000);
		run_instr(8'hBC, 8'h80, 8'h00, 8'h00, 16'h0080, OAG_M_DIR, OAG_C_JUMP, 2'h2, 1'b1, 16'h0200);
	endtask

	task automatic t_branch_bit();
		run_instr(8'h05, 8'h33, 8'hFE, 8'h00, 16'h0033, OAG_M_DIR, OAG_C_BRBIT, 2'h3, 1'b0, 16'h0000);
		run_instr(8'h0E, 8'h7F, 8'h02, 8'h00, 16'h007F, OAG_M_DIR, OAG_C_BRBIT, 2'h3, 1'b0, 16'h0000);
	endtask

	task automatic t_extended();
		run_instr(8'hC6, 8'h12, 8'h34, 8'h55, 16'h1234, OAG_M_EXT, OAG_C_REGMEM, 2'h3, 1'b0, 16'h0000);
		run_instr(8'hCD, 8'hF0, 8'h0F, 8'h00, 16'hF00F, OAG_M_EXT, OAG_C_JUMP, 2'h3, 1'b1, 16'h0300);
		// A would-be extended read-modify-write row is not an addressing form here
		run_instr(8'h4C, 8'h00, 8'h00, 8'h00, 16'h0000, OAG_M_NONE, OAG_C_NONE, 2'h1, 1'b1, 16'h0301);
	endtask

	task automatic t_indexed();
		run_instr(8'hF6, 8'hAA, 8'hAA, 8'h7F, 16'h007F, OAG_M_IX, OAG_C_REGMEM, 2'h1, 1'b0, 16'h0000);
		run_instr(8'hE6, 8'hFF, 8'h00, 8'hFF, 16'h01FE, OAG_M_IX1, OAG_C_REGMEM, 2'h2, 1'b0, 16'h0000);
		run_instr(8'hE7, 8'h80, 8'h00, 8'h81, 16'h0101, OAG_M_IX1, OAG_C_REGMEM, 2'h2, 1'b0, 16'h0000);
		run_instr(8'hD6, 8'h12, 8'hF0, 8'h20, 16'h1310, OAG_M_IX2, OAG_C_REGMEM, 2'h3, 1'b0, 16'h0000);
		run_instr(8'hDE, 8'h01, 8'h00, 8'h00, 16'h0100, OAG_M_IX2, OAG_C_REGMEM, 2'h3, 1'b0, 16'h0000);
		run_instr(8'h7D, 8'h00, 8'h00, 8'h44, 16'h0044, OAG_M_IX, OAG_C_RMW, 2'h1, 1'b0, 16'h0000);
		run_instr(8'h6C, 8'h05, 8'h00, 8'h03, 16'h0008, OAG_M_IX1, OAG_C_RMW, 2'h2, 1'b0, 16'h0000);
		run_instr(8'h5C, 8'h00, 8'h00, 8'h00, 16'h0000, OAG_M_NONE, OAG_C_NONE, 2'h1, 1'b1, 16'h0400);
		run_instr(8'hDC, 8'h00, 8'h80, 8'h01, 16'h0081, OAG_M_IX2, OAG_C_JUMP, 2'h3, 1'b1, 16'h0500);
		run_instr(8'hED, 8'h10, 8'h00, 8'hF0, 16'h0100, OAG_M_IX1, OAG_C_JUMP, 2'h2, 1'b1, 16'h0600);
		run_instr(8'hFC, 8'h00, 8'h00, 8'h3C, 16'h003C, OAG_M_IX, OAG_C_JUMP, 2'h1, 1'b1, 16'h0700);
	endtask

	// ***********************************************
	// Main sequence
	// ***********************************************
	initial begin
		repeat (8) @(posedge clk);
		#1;
		t_reset();
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_direct();
		t_branch_bit();
		t_extended();
		t_indexed();
		end_sim();
	end
endmodule

`default_nettype wire
